// File: hdl/asf_top.sv
// Auxiliary status, latched-fault and pin-3 control registers of a power,
// charge and energy monitor, reached from the two-wire serial engine.
// Assumes the serial engine runs on link_clk and the measurement datapath,
// pin configuration and alert logic run on core_clk.
//
// What this block does
// - Pin 1 state reads one when active
// - Pin 2 state: active level, or raw pin level when accumulating
// - Pin 3 state reads one when active
// - Status shows converter busy in snapshot mode
// - Live bits mirror energy, charge, time overflow
// - Overflows set matching sticky fault bits
// - Active general inputs set their fault bits
// - Armed stuck-bus wake-up sets a fault bit
// - Alert bit sets on alert or written one
// - Alert bit pulls pin 3 low in alert mode
// - Pull-down bit drives pin 3 in output mode
// - Codes 11 and 10 mean input high/low active
// - Pin 2 code 00 is accumulate input
// - Pin 3 code 00 is alert output
`include "asf_params.svh"

module asf_top (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              link_clk,
  input  wire logic              link_srst,
  input  wire logic              req_valid,
  input  wire asf_pkg::asf_req_s req,
  output logic                   req_busy,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_rdata,
  input  wire logic              general_pin_1_in,
  input  wire logic              general_pin_2_in,
  input  wire logic              general_pin_3_in,
  output logic                   general_pin_3_out,
  output logic                   general_pin_3_oe,
  input  wire logic [7:0]        pin_config_field,
  input  wire logic [7:0]        control_b_field,
  input  wire logic              adc_snapshot_busy,
  input  wire asf_pkg::asf_ovf_s ovf,
  input  wire logic              stuck_bus_wake,
  input  wire logic              alert_event,
  output logic                   alert_pending
);

  // ========================================================================
  // Decode helpers

  // True when a pin configured as a general input sits at its active level
  function automatic logic pin_active(input logic [1:0] cfg, input logic lvl);
    logic act;
    act = 1'b0;
    if (cfg == `ASF_CFG_IN_HIGH) begin
      act = lvl;
    end else if (cfg == `ASF_CFG_IN_LOW) begin
      act = ~lvl;
    end
    return act;
  endfunction : pin_active

  localparam asf_pkg::asf_core_st_s ST_RST = '{faults: `ASF_FAULT_RST, default: '0};

  asf_pkg::asf_core_st_s st;
  asf_pkg::asf_core_st_s nxt_st;

  asf_pkg::asf_req_s xfer_req;
  logic              xfer_tgl;

  logic [1:0] cfg1;
  logic [1:0] cfg2;
  logic [1:0] cfg3;
  logic       act1;
  logic       act2;
  logic       act3;
  logic       state2;
  logic [7:0] live;
  logic [7:0] fault_set;
  logic       acc;
  logic       wr_faults;
  logic       wr_pin3;

  // ========================================================================
  // Link-side access port
  asf_link_port u_link (
    .link_clk   (link_clk),
    .link_srst  (link_srst),
    .req_valid  (req_valid),
    .req        (req),
    .req_busy   (req_busy),
    .rsp_valid  (rsp_valid),
    .rsp_rdata  (rsp_rdata),
    .xfer_req   (xfer_req),
    .xfer_tgl   (xfer_tgl),
    .ack_tgl    (st.ack),
    .core_rdata (st.rdata)
  );

  // ========================================================================
  // Pin decode
  // Pins are read only after the second synchroniser stage.
  always_comb begin
    cfg1   = pin_config_field[`ASF_CFG_P1_HI:`ASF_CFG_P1_LO];
    cfg2   = pin_config_field[`ASF_CFG_P2_HI:`ASF_CFG_P2_LO];
    cfg3   = pin_config_field[`ASF_CFG_P3_HI:`ASF_CFG_P3_LO];
    act1   = pin_active(cfg1, st.pin_s2[2]);
    act2   = pin_active(cfg2, st.pin_s2[1]);
    act3   = pin_active(cfg3, st.pin_s2[0]);
    // Accumulate input reports the raw level, not an active level
    state2 = (cfg2 == `ASF_CFG_ALT) ? st.pin_s2[1] : act2;
  end

  // ========================================================================
  // Live status and fault sources
  always_comb begin
    live                    = 8'h00;
    live[7]                 = `ASF_LIVE_RSVD;
    live[`ASF_BIT_PIN1]     = act1;
    live[`ASF_BIT_PIN2]     = state2;
    live[`ASF_BIT_PIN3]     = act3;
    live[`ASF_BIT_ADC_BUSY] = adc_snapshot_busy;
    live[`ASF_BIT_ENERGY]   = ovf.energy;
    live[`ASF_BIT_CHARGE]   = ovf.charge;
    live[`ASF_BIT_TIME]     = ovf.time_cnt;

    // Overflows are levels, so the fault sets every cycle the level holds
    // and a host clear during an overflow does not stick.
    fault_set                  = 8'h00;
    fault_set[`ASF_BIT_PIN1]   = act1;
    fault_set[`ASF_BIT_PIN2]   = act2;
    fault_set[`ASF_BIT_PIN3]   = act3;
    fault_set[`ASF_BIT_WAKE]   = stuck_bus_wake & control_b_field[`ASF_CB_WAKE_EN];
    fault_set[`ASF_BIT_ENERGY] = ovf.energy;
    fault_set[`ASF_BIT_CHARGE] = ovf.charge;
    fault_set[`ASF_BIT_TIME]   = ovf.time_cnt;
  end

  // ========================================================================
  // Register access and state update
  always_comb begin
    nxt_st        = st;
    nxt_st.pin_s1 = {general_pin_1_in, general_pin_2_in, general_pin_3_in};
    nxt_st.pin_s2 = st.pin_s1;
    nxt_st.rq_s1  = xfer_tgl;
    nxt_st.rq_s2  = st.rq_s1;
    nxt_st.rq_s3  = st.rq_s2;

    acc       = st.rq_s2 != st.rq_s3;
    wr_faults = acc && xfer_req.write && (xfer_req.addr == `ASF_ADDR_FAULTS);
    wr_pin3   = acc && xfer_req.write && (xfer_req.addr == `ASF_ADDR_PIN3);

    if (acc) begin
      nxt_st.ack = ~st.ack;
      unique case (xfer_req.addr)
        `ASF_ADDR_LIVE:   nxt_st.rdata = live;
        `ASF_ADDR_FAULTS: nxt_st.rdata = st.faults;
        `ASF_ADDR_PIN3:   nxt_st.rdata = {st.alert, st.pull, `ASF_PIN3_RSVD};
        default:          nxt_st.rdata = `ASF_RD_UNMAPPED;
      endcase
    end

    // New events win over a host clear in the same cycle
    nxt_st.faults = (wr_faults ? xfer_req.wdata : st.faults)
                    | fault_set | `ASF_FAULT_RSVD;
    nxt_st.alert  = (wr_pin3 ? xfer_req.wdata[`ASF_BIT_ALERT] : st.alert)
                    | alert_event;
    nxt_st.pull   = wr_pin3 ? xfer_req.wdata[`ASF_BIT_PULL] : st.pull;

    // Pin 3 is open drain: it only ever pulls low
    nxt_st.pin3_out = 1'b0;
    unique case (cfg3)
      `ASF_CFG_ALT:    nxt_st.pin3_oe = nxt_st.alert;
      `ASF_CFG_OUTPUT: nxt_st.pin3_oe = nxt_st.pull;
      default:         nxt_st.pin3_oe = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= ST_RST;
    end else begin
      st <= nxt_st;
    end
  end

  assign general_pin_3_out = st.pin3_out;
  assign general_pin_3_oe  = st.pin3_oe;
  assign alert_pending     = st.alert;

  // ========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  logic rd_live;
  assign rd_live = acc && !xfer_req.write && (xfer_req.addr == `ASF_ADDR_LIVE);

  live_pin1_a : assert property (
    rd_live && cfg1[1] |=> st.rdata[`ASF_BIT_PIN1] == ($past(cfg1[0]) ~^ $past(st.pin_s2[2])))
    else $error("pin 1 state does not follow its active level");

  live_pin2_a : assert property (
    rd_live && (cfg2 == `ASF_CFG_ALT) |=> st.rdata[`ASF_BIT_PIN2] == $past(st.pin_s2[1]))
    else $error("pin 2 state wrong in accumulate mode");

  live_pin3_a : assert property (
    rd_live && !cfg3[1] |=> !st.rdata[`ASF_BIT_PIN3])
    else $error("pin 3 state set while not an input");

  live_busy_a : assert property (
    rd_live |=> st.rdata[`ASF_BIT_ADC_BUSY] == $past(adc_snapshot_busy))
    else $error("busy bit does not show converter state");

  live_ovf_a : assert property (
    rd_live |=> st.rdata[2:0] == $past({ovf.energy, ovf.charge, ovf.time_cnt}))
    else $error("overflow status bits do not follow the counters");

  ovf_fault_a : assert property (
    ovf.energy |=> st.faults[`ASF_BIT_ENERGY])
    else $error("energy overflow fault not recorded");

  pin_fault_a : assert property (
    act1 |=> st.faults[`ASF_BIT_PIN1])
    else $error("pin 1 fault not recorded");

  wake_fault_a : assert property (
    stuck_bus_wake && control_b_field[`ASF_CB_WAKE_EN] |=> st.faults[`ASF_BIT_WAKE])
    else $error("stuck-bus wake-up fault not recorded");

  alert_clear_a : assert property (
    $fell(st.alert) |-> $past(wr_pin3 && !xfer_req.wdata[`ASF_BIT_ALERT] && !alert_event))
    else $error("alert bit cleared without a host write of zero");

  pin3_alert_a : assert property (
    cfg3 == `ASF_CFG_ALT |=> general_pin_3_oe == st.alert && !general_pin_3_out)
    else $error("pin 3 not following alert bit in alert mode");

  pin3_pull_a : assert property (
    cfg3 == `ASF_CFG_OUTPUT |=> general_pin_3_oe == st.pull)
    else $error("pin 3 not following pull-down bit");

  fault_sticky_a : assert property (
    $fell(st.faults[`ASF_BIT_CHARGE]) |-> $past(wr_faults) && st.faults[7])
    else $error("fault bit dropped without a host write");

endmodule : asf_top

// File: hdl/asf_params.svh
// Named offsets, field positions, codes and reset values of the auxiliary
// status, latched-fault and pin-3 control registers.
// Assumes it is included by its bare name from every file that needs it.
`ifndef ASF_PARAMS_SVH
`define ASF_PARAMS_SVH

// ==========================================================================
// Register offsets
`define ASF_ADDR_LIVE      8'h40
`define ASF_ADDR_FAULTS    8'h41
`define ASF_ADDR_PIN3      8'h42
`define ASF_RD_UNMAPPED    8'h00

// ==========================================================================
// Bit positions in the live status and latched fault registers
`define ASF_BIT_PIN1       6
`define ASF_BIT_PIN2       5
`define ASF_BIT_PIN3       4
`define ASF_BIT_ADC_BUSY   3
`define ASF_BIT_WAKE       3
`define ASF_BIT_ENERGY     2
`define ASF_BIT_CHARGE     1
`define ASF_BIT_TIME       0

// ==========================================================================
// Pin-3 control register fields
`define ASF_BIT_ALERT      7
`define ASF_BIT_PULL       6
`define ASF_PIN3_RSVD      6'h00

// ==========================================================================
// Reset values; the top fault bit is reserved and reads as one
`define ASF_FAULT_RST      8'h80
`define ASF_FAULT_RSVD     8'h80
`define ASF_LIVE_RSVD      1'h0

// ==========================================================================
// Pin configuration field: codes and field positions
`define ASF_CFG_IN_HIGH    2'h3
`define ASF_CFG_IN_LOW     2'h2
`define ASF_CFG_OUTPUT     2'h1
`define ASF_CFG_ALT        2'h0
`define ASF_CFG_P1_HI      7
`define ASF_CFG_P1_LO      6
`define ASF_CFG_P2_HI      5
`define ASF_CFG_P2_LO      4
`define ASF_CFG_P3_HI      3
`define ASF_CFG_P3_LO      2

// ==========================================================================
// Control field bit that arms the stuck-bus wake-up fault
`define ASF_CB_WAKE_EN     4

`endif

// File: hdl/asf_pkg.sv
// Types shared by the register bank and its link-side access port.
// Assumes nothing beyond a SystemVerilog compiler.
package asf_pkg;

  // ========================================================================
  // Register access request as handed over by the serial engine
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asf_req_s;

  // ========================================================================
  // Live overflow conditions from the accumulators
  typedef struct packed {
    logic energy;
    logic charge;
    logic time_cnt;
  } asf_ovf_s;

  // ========================================================================
  // Link-side state
  typedef struct packed {
    asf_req_s   req;
    logic       tgl;
    logic       busy;
    logic       ack_s1;
    logic       ack_s2;
    logic       ack_s3;
    logic       rsp_valid;
    logic [7:0] rsp_rdata;
  } asf_link_st_s;

  // ========================================================================
  // Core-side state
  typedef struct packed {
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic       rq_s1;
    logic       rq_s2;
    logic       rq_s3;
    logic       ack;
    logic [7:0] rdata;
    logic [7:0] faults;
    logic       alert;
    logic       pull;
    logic       pin3_out;
    logic       pin3_oe;
  } asf_core_st_s;

endpackage : asf_pkg

// File: hdl/asf_link_port.sv
// Link-clock side of the register access path: takes one request at a time
// from the serial engine and hands it to the core clock by a toggle handshake.
// Assumes link_srst and the core reset are applied together.
`include "asf_params.svh"

module asf_link_port (
  input  wire logic             link_clk,
  input  wire logic             link_srst,
  input  wire logic             req_valid,
  input  wire asf_pkg::asf_req_s req,
  output logic                  req_busy,
  output logic                  rsp_valid,
  output logic [7:0]            rsp_rdata,
  output asf_pkg::asf_req_s     xfer_req,
  output logic                  xfer_tgl,
  input  wire logic             ack_tgl,
  input  wire logic [7:0]       core_rdata
);

  asf_pkg::asf_link_st_s st;
  asf_pkg::asf_link_st_s nxt_st;

  // ========================================================================
  // Handshake
  // The request word stays frozen while busy, so the core may sample it
  // as soon as it sees the toggle move.
  always_comb begin
    nxt_st           = st;
    nxt_st.ack_s1    = ack_tgl;
    nxt_st.ack_s2    = st.ack_s1;
    nxt_st.ack_s3    = st.ack_s2;
    nxt_st.rsp_valid = 1'b0;
    if (st.busy && (st.ack_s2 != st.ack_s3)) begin
      nxt_st.busy      = 1'b0;
      nxt_st.rsp_valid = 1'b1;
      nxt_st.rsp_rdata = core_rdata;
    end else if (!st.busy && req_valid) begin
      nxt_st.req  = req;
      nxt_st.tgl  = ~st.tgl;
      nxt_st.busy = 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      st <= '0;
    end else begin
      st <= nxt_st;
    end
  end

  assign req_busy  = st.busy;
  assign rsp_valid = st.rsp_valid;
  assign rsp_rdata = st.rsp_rdata;
  assign xfer_req  = st.req;
  assign xfer_tgl  = st.tgl;

  // ========================================================================
  // Checks
  resp_done_a : assert property (@(posedge link_clk) disable iff (link_srst)
    st.rsp_valid |-> !st.busy && $past(st.busy))
    else $error("response without an outstanding request");

  req_hold_a : assert property (@(posedge link_clk) disable iff (link_srst)
    st.busy && $past(st.busy) |-> $stable(st.req) && $stable(st.tgl))
    else $error("request word changed while in flight");

endmodule : asf_link_port

// File: verif/asf_host_model.sv
// Host-side model of the serial engine: one register access at a time.
// Assumes it faces the link port of the block on the same link clock.
module asf_host_model (
  input  wire logic         link_clk,
  input  wire logic         req_busy,
  input  wire logic         rsp_valid,
  input  wire logic [7:0]   rsp_rdata,
  output logic              req_valid,
  output asf_pkg::asf_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // ==========================================================================
  // Access; idle gap first so both prompt and slow hosts are exercised
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input int gap, output logic [7:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 8'hXX;
    // Always start on a link falling edge, and never offer into a busy port
    repeat (gap + 1) @(negedge link_clk);
    while (req_busy === 1'b1) begin
      @(negedge link_clk);
    end
    req_valid = 1'b1;
    req       = '{write: w, addr: a, wdata: d};
    @(posedge link_clk);
    @(negedge link_clk);
    req_valid = 1'b0;
    // Released lines show the inverse so stale data cannot pass for fresh
    req       = ~req;
    for (n = 0; n < 40 && ok !== 1'b1; n++) begin
      @(negedge link_clk);
      if (rsp_valid === 1'b1) begin
        rd = rsp_rdata;
        ok = 1'b1;
      end
    end
  endtask : acc
endmodule : asf_host_model

// File: verif/aux_status_fault_pin_control_tb_top.sv
// Self-checking bench of the auxiliary status, fault and pin-3 registers.
// Assumes a pull-up on pin 3 and the host model on the link side.
`include "asf_params.svh"

module aux_status_fault_pin_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic              core_clk, srst, link_clk, link_srst;
  logic              req_valid, req_busy, rsp_valid;
  logic [7:0]        rsp_rdata, cfg, cb, mf;
  asf_pkg::asf_req_s req;
  asf_pkg::asf_ovf_s ovf;
  logic              p1, p2, p3, p3w, p3_out, p3_oe, adc, wake, alert_ev, pend;
  int                n_errors, n_checks;

  // Open-drain pin 3 with pull-up
  assign p3w = p3_oe ? 1'b0 : p3;

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #11;
    forever #32 link_clk = ~link_clk;
  end

  asf_top u_asf_top (.core_clk(core_clk), .srst(srst), .link_clk(link_clk),
    .link_srst(link_srst), .req_valid(req_valid), .req(req), .req_busy(req_busy),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .general_pin_1_in(p1),
    .general_pin_2_in(p2), .general_pin_3_in(p3w), .general_pin_3_out(p3_out),
    .general_pin_3_oe(p3_oe), .pin_config_field(cfg), .control_b_field(cb),
    .adc_snapshot_busy(adc), .ovf(ovf), .stuck_bus_wake(wake),
    .alert_event(alert_ev), .alert_pending(pend));

  asf_host_model u_asf_host_model (.link_clk(link_clk), .req_busy(req_busy),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .req_valid(req_valid), .req(req));

  // ==========================================================================
  // Reference model
  function automatic logic act(input logic [1:0] c, input logic l);
    return c[1] & (l ~^ c[0]);
  endfunction : act

  function automatic logic [7:0] live_exp();
    return {1'b0, act(cfg[7:6], p1), act(cfg[5:4], p2) | (cfg[5:4] == 2'b00 && p2),
            act(cfg[3:2], p3w), adc, ovf};
  endfunction : live_exp

  function automatic logic [7:0] fev();
    return {1'b0, act(cfg[7:6], p1), act(cfg[5:4], p2), act(cfg[3:2], p3w),
            cb[4] & wake, ovf};
  endfunction : fev

  // ==========================================================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    logic [7:0] r;
    logic       ok;
    u_asf_host_model.acc(w, a, d, $urandom % 3, r, ok);
    // Back onto a core falling edge so later stimulus keeps its timing
    @(negedge core_clk);
    chk($sformatf("done %h", a), 8'h01, {7'h00, ok});
    if (!w) begin
      chk($sformatf("read %h", a), e, r);
    end
  endtask : acc

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #500us;
    n_errors++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    srst = 1'b1;
    link_srst = 1'b1;
    {p1, p2, p3, adc, wake, alert_ev} = 6'h08;
    cfg = 8'h00;
    cb = 8'h00;
    ovf = '0;
    n_errors = 0;
    n_checks = 0;
    mf = 8'h80;
    void'($urandom(6));
    cyc(4);
    srst = 1'b0;
    repeat (4) @(negedge link_clk);
    link_srst = 1'b0;
    cyc(8);
    chk("reset oe", 8'h00, {7'h00, p3_oe});
    acc(1'b0, `ASF_ADDR_FAULTS, 8'h00, 8'h80);
    acc(1'b0, `ASF_ADDR_PIN3, 8'h00, 8'h00);
    acc(1'b1, `ASF_ADDR_LIVE, 8'hFF, 8'h00);
    acc(1'b0, `ASF_ADDR_LIVE, 8'h00, live_exp());
    acc(1'b1, 8'h17, 8'hFF, 8'h00);
    acc(1'b0, 8'h17, 8'h00, 8'h00);
    // Pins settle before the config moves, so transients stay predictable
    for (int i = 0; i < 20; i++) begin
      {p1, p2, p3, adc} = 4'($urandom);
      cyc(4);
      mf |= fev();
      cfg = 8'($urandom);
      cb = 8'($urandom);
      ovf = 3'($urandom);
      cyc(4);
      mf |= fev();
      acc(1'b0, `ASF_ADDR_LIVE, 8'h00, live_exp());
      acc(1'b0, `ASF_ADDR_FAULTS, 8'h00, mf);
      d = 8'($urandom);
      acc(1'b1, `ASF_ADDR_FAULTS, d, 8'h00);
      mf = d | 8'h80 | fev();
      acc(1'b0, `ASF_ADDR_FAULTS, 8'h00, mf);
    end
    {p1, p2, p3, adc} = 4'h0;
    cyc(4);
    mf |= fev();
    cfg = 8'h00;
    ovf = '0;
    for (int k = 0; k < 2; k++) begin
      cb = k[0] ? 8'h10 : 8'hEF;
      wake = 1'b1;
      cyc(1);
      wake = 1'b0;
      mf |= k[0] ? 8'h08 : 8'h00;
      acc(1'b0, `ASF_ADDR_FAULTS, 8'h00, mf);
    end
    alert_ev = 1'b1;
    cyc(1);
    alert_ev = 1'b0;
    cyc(3);
    chk("pending", 8'h01, {7'h00, pend});
    chk("oe alert", 8'h01, {7'h00, p3_oe});
    acc(1'b0, `ASF_ADDR_PIN3, 8'h00, 8'h80);
    cfg[3:2] = 2'b11;
    cyc(3);
    chk("oe input", 8'h00, {7'h00, p3_oe});
    cfg[3:2] = 2'b00;
    acc(1'b1, `ASF_ADDR_PIN3, 8'h00, 8'h00);
    cyc(3);
    chk("cleared", 8'h00, {6'h00, pend, p3_oe});
    acc(1'b1, `ASF_ADDR_PIN3, 8'h80, 8'h00);
    cyc(3);
    chk("set by host", 8'h03, {6'h00, pend, p3_oe});
    acc(1'b1, `ASF_ADDR_PIN3, 8'h7F, 8'h00);
    cfg[3:2] = 2'b01;
    cyc(3);
    chk("pull low", 8'h01, {6'h00, pend, p3_oe});
    acc(1'b0, `ASF_ADDR_PIN3, 8'h00, 8'h40);
    cfg[3:2] = 2'b00;
    cyc(3);
    chk("pull ignored", 8'h00, {6'h00, p3_out, p3_oe});
    end_of_test();
  end
endmodule : aux_status_fault_pin_control_tb_top
